// ===== dsp_tile.sv
// Configurable multiply, add and accumulate tile.
//
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps

// Operation
// RULE_01: Summation adds first-level adder outputs: two sums at 9 bits, one at 18.
// RULE_02: Output multiplexer picks product, adder/accumulator or summation result by mode.
// RULE_03: Output registers optional; each set picks one of four clock/clear/enable sets.
// RULE_04: The tile runs one mode at a time; mixing modes is not allowed.
// RULE_05: Simple mode sends four 18-bit or eight 9-bit products straight out.
// RULE_06: A 36x36 product is built from four 18-bit products, adder and shifts.
// RULE_07: In 36-bit mode the shift chain is disabled; operands load in parallel.
// RULE_08: In 36-bit mode the product register pipelines the wide multiplication.
// RULE_09: One or two accumulators fed by the second and fourth multipliers only.
// RULE_10: Each accumulator is 52 bits: 36-bit product plus 16 bits headroom.
// RULE_11: Accumulator load and overflow work only in multiply-accumulate mode.
// RULE_12: Add/subtract select lets the accumulator subtract; overflow covers underflow.
// RULE_13: Two-multiplier adder gives two 18-bit or four 9-bit pair sums or differences.
// RULE_14: Complex product: subtractor gives real part, adder gives imaginary part.
// RULE_15: Four-multiplier adder adds two first-stage adder results.
// RULE_16: Summed multipliers must all share one product width.
// RULE_17: Four-multiplier adder with shift chains forms a four-tap 18-bit filter.
// RULE_18: Shift chains pass from tile to tile and can leave the tile.
// RULE_19: Eight interface units, each half an 18-bit multiplier, 18 in and 18 out.
// RULE_20: Control bus: four clocks, clears, enables, two signs, add/subs, loads.
// RULE_21: Sign select high means two's complement; product signed if either is.
// RULE_22: First-level adder adds when its select is high, subtracts when low.
// RULE_23: Accumulator load replaces the total with the product on the next edge.
// RULE_24: Output registers are always used when accumulating.
// RULE_25: Each register clears on its selected clear and updates only when enabled.
// RULE_26: Overflow is registered and flags leaving the 52-bit range either way.
module dsp_tile (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [dsp_tile_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [3:0][17:0] a_data,
  input wire logic [3:0][17:0] b_data,
  input wire logic [17:0] chain_in_first_operand,
  input wire logic [17:0] chain_in_second_operand,
  input wire logic [3:0] clock_tick,
  input wire logic [3:0] clock_ena,
  input wire logic [3:0] async_clear,
  input wire logic sign_a,
  input wire logic sign_b,
  input wire logic [1:0] add_sub,
  input wire logic [1:0] acc_load,
  output logic [dsp_tile_pkg::OUTW-1:0] result,
  output logic [1:0] overflow,
  output logic [17:0] chain_out_first_operand,
  output logic [17:0] chain_out_second_operand
);
  import dsp_tile_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [CFG_W-1:0] cfg;
    logic [SEL_W-1:0] sel;
    logic [UNITS-1:0][OPW-1:0] a_in;
    logic [UNITS-1:0][OPW-1:0] b_in;
    logic [1:0] sgn_in;
    logic [1:0] as_in;
    logic [1:0] ld_in;
    logic [NPROD-1:0][PRODW-1:0] prod;
    logic [1:0] sgn_p;
    logic [1:0] as_p;
    logic [1:0] ld_p;
    logic [1:0][ACCW-1:0] acc;
    logic [1:0] ovf;
    logic [OUTW-1:0] res;
    logic [31:0] rdata;
  } state_type;

  state_type s;
  state_type next_s;

  // ****************************************
  // Functions
  // ****************************************
  // Full-precision 18x18 product, each operand signed or unsigned.
  function automatic logic [PRODW-1:0] mul18(input logic [OPW-1:0] x, input logic [OPW-1:0] y,
                                             input logic sx, input logic sy);
    logic signed [OPW:0] xs;
    logic signed [OPW:0] ys;
    logic signed [2*OPW+1:0] p;
    xs = {sx & x[OPW-1], x};
    ys = {sy & y[OPW-1], y};
    p = xs * ys;
    return p[PRODW-1:0];
  endfunction

  // Widens a 9-bit field to 18 bits by sign or zero.
  function automatic logic [OPW-1:0] ext9(input logic [HALFW-1:0] v, input logic sg);
    return {{HALFW{sg & v[HALFW-1]}}, v};
  endfunction

  // Widens a product to the full internal width by sign or zero.
  function automatic logic [WIDEW-1:0] ext36(input logic [PRODW-1:0] v, input logic sg);
    return {{(WIDEW-PRODW){sg & v[PRODW-1]}}, v};
  endfunction

  function automatic logic [WIDEW-1:0] addsub(input logic [WIDEW-1:0] x, input logic [WIDEW-1:0] y,
                                              input logic add);
    return add ? x + y : x - y;
  endfunction

  // Register set update strobe for a selected set.
  function automatic logic set_gate(input logic [1:0] k, input logic [3:0] tick, input logic [3:0] ena);
    return tick[k] & ena[k]; // RULE_20
  endfunction

  // ****************************************
  // Datapath and registers
  // ****************************************
  mode_type mode;
  width_type wid;
  logic [1:0] sel_in;
  logic [1:0] sel_pipe;
  logic [1:0] sel_out;
  logic in_en;
  logic pipe_en;
  logic out_en;
  logic chain_a;
  logic chain_b;
  logic [UNITS-1:0][OPW-1:0] a_shift;
  logic [UNITS-1:0][OPW-1:0] b_shift;
  logic [UNITS-1:0][OPW-1:0] op_a;
  logic [UNITS-1:0][OPW-1:0] op_b;
  logic [1:0] sgn_v;
  logic [1:0] as_v;
  logic [1:0] ld_v;
  logic [NPROD-1:0][PRODW-1:0] prod_c;
  logic [NPROD-1:0][PRODW-1:0] pv;
  logic [1:0] sgn_d;
  logic [1:0] as_d;
  logic [1:0] ld_d;
  logic psg;
  logic [NPROD-1:0][WIDEW-1:0] e;
  logic [3:0][WIDEW-1:0] fa;
  logic [1:0][WIDEW-1:0] sum;
  logic [WIDEW-1:0] wide;
  logic [OUTW-1:0] out_c;
  logic [ACCW:0] acc53;
  logic [ACCW:0] p53;
  logic [ACCW:0] tot;
  logic [WIDEW-1:0] src;
  int unit;

  always_comb begin
    next_s = s;
    mode = mode_type'(s.cfg[CFG_MODE_LSB +: 2]); // RULE_04
    wid = width_type'(s.cfg[CFG_WIDTH_LSB +: 2]);
    sel_in = s.sel[SEL_IN_LSB +: 2];
    sel_pipe = s.sel[SEL_PIPE_LSB +: 2];
    sel_out = s.sel[SEL_OUT_LSB +: 2];
    in_en = s.cfg[CFG_IN_REG];
    pipe_en = s.cfg[CFG_PIPE_REG] || (wid == WIDTH_36); // RULE_08
    out_en = s.cfg[CFG_OUT_REG] || (mode == MODE_MAC); // RULE_24
    chain_a = s.cfg[CFG_CHAIN_A] && (wid != WIDTH_36); // RULE_07
    chain_b = s.cfg[CFG_CHAIN_B] && (wid != WIDTH_36); // RULE_07

    // Register port: a read answers in the next cycle only.
    next_s.rdata = 32'h0;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_CFG: next_s.cfg = reg_wdata[CFG_W-1:0];
        ADDR_SEL: next_s.sel = reg_wdata[SEL_W-1:0];
        default: next_s.cfg = s.cfg;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CFG: next_s.rdata = {{(32-CFG_W){1'b0}}, s.cfg};
        ADDR_SEL: next_s.rdata = {{(32-SEL_W){1'b0}}, s.sel};
        ADDR_STAT: next_s.rdata = {30'h0, s.ovf};
        default: next_s.rdata = 32'h0;
      endcase
    end

    // Input registers, loaded in parallel or shifted along the chains.
    a_shift = {s.a_in[UNITS-2:0], chain_in_first_operand}; // RULE_18
    b_shift = {s.b_in[UNITS-2:0], chain_in_second_operand}; // RULE_18
    if (async_clear[sel_in]) begin // RULE_25
      next_s.a_in = '0;
      next_s.b_in = '0;
      next_s.sgn_in = 2'h0;
      next_s.as_in = 2'h0;
      next_s.ld_in = 2'h0;
    end else if (set_gate(sel_in, clock_tick, clock_ena)) begin // RULE_25
      next_s.a_in = chain_a ? a_shift : a_data; // RULE_17
      next_s.b_in = chain_b ? b_shift : b_data; // RULE_17
      next_s.sgn_in = {sign_a, sign_b};
      next_s.as_in = add_sub;
      next_s.ld_in = acc_load;
    end
    op_a = (in_en || chain_a) ? s.a_in : a_data; // RULE_19
    op_b = (in_en || chain_b) ? s.b_in : b_data; // RULE_19
    sgn_v = in_en ? s.sgn_in : {sign_a, sign_b};
    as_v = in_en ? s.as_in : add_sub;
    ld_v = in_en ? s.ld_in : acc_load;

    // Multipliers.
    for (int k = 0; k < NPROD; k++) begin
      unit = k / 2;
      prod_c[k] = '0;
      case (wid)
        WIDTH_9: prod_c[k] = mul18(ext9(op_a[unit][HALFW*(k%2) +: HALFW], sgn_v[1]),
                                   ext9(op_b[unit][HALFW*(k%2) +: HALFW], sgn_v[0]),
                                   sgn_v[1], sgn_v[0]);
        WIDTH_18: if (k < UNITS) prod_c[k] = mul18(op_a[k], op_b[k], sgn_v[1], sgn_v[0]); // RULE_21
        WIDTH_36: begin // RULE_06
          case (k)
            0: prod_c[k] = mul18(op_a[0], op_b[0], 1'b0, 1'b0);
            1: prod_c[k] = mul18(op_a[1], op_b[0], sgn_v[1], 1'b0);
            2: prod_c[k] = mul18(op_a[0], op_b[1], 1'b0, sgn_v[0]);
            3: prod_c[k] = mul18(op_a[1], op_b[1], sgn_v[1], sgn_v[0]);
            default: prod_c[k] = '0;
          endcase
        end
        default: prod_c[k] = '0;
      endcase
    end

    // Pipeline register behind the multipliers.
    if (async_clear[sel_pipe]) begin // RULE_25
      next_s.prod = '0;
      next_s.sgn_p = 2'h0;
      next_s.as_p = 2'h0;
      next_s.ld_p = 2'h0;
    end else if (set_gate(sel_pipe, clock_tick, clock_ena)) begin // RULE_25
      next_s.prod = prod_c;
      next_s.sgn_p = sgn_v;
      next_s.as_p = as_v;
      next_s.ld_p = ld_v;
    end
    pv = pipe_en ? s.prod : prod_c; // RULE_08
    sgn_d = pipe_en ? s.sgn_p : sgn_v;
    as_d = pipe_en ? s.as_p : as_v;
    ld_d = pipe_en ? s.ld_p : ld_v;
    psg = sgn_d[1] | sgn_d[0]; // RULE_21

    for (int k = 0; k < NPROD; k++) begin
      e[k] = ext36(pv[k], psg);
    end

    // Wide product: partial products weighted by 2^36, 2^18 and 1.
    wide = (ext36(pv[3], psg) << 36) // RULE_06
         + ((ext36(pv[1], sgn_d[1]) + ext36(pv[2], sgn_d[0])) << 18)
         + ext36(pv[0], 1'b0);

    // First-level adders: pairs share one select per half at 9 bits.
    for (int j = 0; j < 4; j++) begin
      fa[j] = addsub(e[2*j], e[2*j+1], (wid == WIDTH_9) ? as_d[j/2] : as_d[j%2]); // RULE_22
    end
    sum[0] = fa[0] + fa[1]; // RULE_01
    sum[1] = fa[2] + fa[3]; // RULE_01

    // Accumulators behind the second and fourth multipliers.
    for (int j = 0; j < 2; j++) begin
      src = (wid == WIDTH_9) ? e[4*j+2] : e[2*j+1]; // RULE_09
      p53 = src[ACCW:0];
      acc53 = {psg & s.acc[j][ACCW-1], s.acc[j]}; // RULE_10
      tot = ld_d[j] ? p53 : (as_d[j] ? acc53 + p53 : acc53 - p53); // RULE_12
      if (mode != MODE_MAC) begin // RULE_11
        next_s.acc[j] = '0;
        next_s.ovf[j] = 1'b0;
      end else if (async_clear[sel_out]) begin // RULE_25
        next_s.acc[j] = '0;
        next_s.ovf[j] = 1'b0;
      end else if (set_gate(sel_out, clock_tick, clock_ena)) begin // RULE_03
        next_s.acc[j] = tot[ACCW-1:0]; // RULE_23
        next_s.ovf[j] = ~ld_d[j] & (psg ? (tot[ACCW] ^ tot[ACCW-1]) : tot[ACCW]); // RULE_26
      end
    end

    // Output selection.
    out_c = '0;
    case (mode) // RULE_02
      MODE_SIMPLE: begin // RULE_05
        case (wid)
          WIDTH_9: for (int k = 0; k < NPROD; k++) out_c[18*k +: 18] = e[k][17:0];
          WIDTH_18: for (int k = 0; k < UNITS; k++) out_c[36*k +: 36] = e[k][35:0];
          default: out_c[WIDEW-1:0] = wide; // RULE_06
        endcase
      end
      MODE_MAC: begin
        for (int j = 0; j < 2; j++) begin
          out_c[WIDEW*j +: WIDEW] = {{(WIDEW-ACCW){psg & next_s.acc[j][ACCW-1]}}, next_s.acc[j]}; // RULE_10
        end
      end
      MODE_TWO: begin // RULE_13
        if (wid == WIDTH_9) begin
          for (int j = 0; j < 4; j++) out_c[36*j +: 36] = fa[j][35:0]; // RULE_14
        end else begin
          for (int j = 0; j < 2; j++) out_c[WIDEW*j +: WIDEW] = fa[j]; // RULE_14
        end
      end
      MODE_FOUR: begin // RULE_15
        if (wid == WIDTH_9) begin
          out_c = {sum[1], sum[0]}; // RULE_01
        end else begin
          out_c[WIDEW-1:0] = sum[0];
        end
      end
      default: out_c = '0;
    endcase

    // Output registers or a plain retiming stage when bypassed.
    if (out_en) begin
      if (async_clear[sel_out]) begin // RULE_25
        next_s.res = '0;
      end else if (set_gate(sel_out, clock_tick, clock_ena)) begin // RULE_03
        next_s.res = out_c;
      end
    end else begin
      next_s.res = out_c;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
      s.cfg <= CFG_RESET;
      s.sel <= SEL_RESET;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign reg_rdata = s.rdata;
  assign result = s.res;
  assign overflow = s.ovf;
  assign chain_out_first_operand = s.a_in[UNITS-1]; // RULE_18
  assign chain_out_second_operand = s.b_in[UNITS-1]; // RULE_18

endmodule

// ===== dsp_tile_chk.sv
// Checker of the multiply tile port behaviour.
`timescale 1ns/10ps
module dsp_tile_chk
  import dsp_tile_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [dsp_tile_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [3:0][17:0] a_data,
  input wire logic [3:0][17:0] b_data,
  input wire logic sign_a,
  input wire logic sign_b,
  input wire logic [1:0] add_sub,
  input wire logic [dsp_tile_pkg::OUTW-1:0] result,
  input wire logic [1:0] overflow
);
  logic [8:0] cfg;
  logic mac_seen;
  logic [35:0] wide_a;
  logic [35:0] wide_b;
  assign wide_a = {a_data[1], a_data[0]};
  assign wide_b = {b_data[1], b_data[0]};
  // Shadow of the mode word, so that datapath checks know the active mode.
  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg <= 9'h000;
      mac_seen <= 1'b0;
    end else if (ce && reg_wr && reg_addr == ADDR_CFG) begin
      cfg <= reg_wdata[8:0];
      if (reg_wdata[1:0] == MODE_MAC) begin
        mac_seen <= 1'b1;
      end
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_cfg_wr; ce && reg_wr && reg_addr == ADDR_CFG; endsequence
  sequence s_cfg_rd; ce && reg_rd && reg_addr == ADDR_CFG; endsequence
  sequence s_wide; cfg == 9'h008 && ce && !sign_a && !sign_b ##1 cfg == 9'h008 && ce; endsequence
  property p_reset;
    disable iff (1'b0) rst |=> result == '0 && overflow == 2'h0 && reg_rdata == 32'h0;
  endproperty
  property p_rd_idle; ce && !reg_rd |=> reg_rdata == 32'h0; endproperty
  property p_unmapped; ce && reg_rd && reg_addr == 2'h3 |=> reg_rdata == 32'h0; endproperty
  property p_cfg_back; s_cfg_wr ##1 s_cfg_rd |=> reg_rdata[8:0] == $past(reg_wdata[8:0], 2); endproperty
  property p_freeze; !ce |=> $stable(result) && $stable(overflow) && $stable(reg_rdata); endproperty
  property p_no_ovf; !mac_seen |-> overflow == 2'h0; endproperty
  property p_simple;
    cfg == 9'h004 && ce && !sign_a && !sign_b |=> result[35:0] == $past(a_data[0]) * $past(b_data[0]);
  endproperty
  property p_two;
    cfg == 9'h007 && ce && add_sub[0] && !sign_a && !sign_b |=>
      result[71:0] == $past(a_data[0]) * $past(b_data[0]) + $past(a_data[1]) * $past(b_data[1]);
  endproperty
  property p_wide; s_wide |=> result[71:0] == $past(wide_a, 2) * $past(wide_b, 2); endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_cfg_back: assert property (p_cfg_back) else $error("mode word readback wrong");
  a_freeze: assert property (p_freeze) else $error("state moved while enable low");
  a_no_ovf: assert property (p_no_ovf) else $error("overflow outside accumulate");
  a_simple: assert property (p_simple) else $error("simple product wrong");
  a_two: assert property (p_two) else $error("pair sum wrong");
  a_wide: assert property (p_wide) else $error("wide product wrong");
endmodule

// ===== dsp_tile_pkg.sv
// Constants, field layouts and types shared by the multiply tile.
package dsp_tile_pkg;

  // ****************************************
  // Register port
  // ****************************************
  localparam int ADDR_W = 2;
  localparam logic [1:0] ADDR_CFG = 2'h0;
  localparam logic [1:0] ADDR_SEL = 2'h1;
  localparam logic [1:0] ADDR_STAT = 2'h2;

  localparam int CFG_W = 9;
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_WIDTH_LSB = 2;
  localparam int CFG_IN_REG = 4;
  localparam int CFG_PIPE_REG = 5;
  localparam int CFG_OUT_REG = 6;
  localparam int CFG_CHAIN_A = 7;
  localparam int CFG_CHAIN_B = 8;
  localparam logic [8:0] CFG_RESET = 9'h000;

  localparam int SEL_W = 6;
  localparam int SEL_IN_LSB = 0;
  localparam int SEL_PIPE_LSB = 2;
  localparam int SEL_OUT_LSB = 4;
  localparam logic [5:0] SEL_RESET = 6'h00;

  // ****************************************
  // Datapath sizes
  // ****************************************
  localparam int UNITS = 4;
  localparam int OPW = 18;
  localparam int HALFW = 9;
  localparam int PRODW = 36;
  localparam int NPROD = 8;
  localparam int WIDEW = 72;
  localparam int ACCW = 52;
  localparam int OUTW = 144;
  localparam int NSETS = 4;

  // ****************************************
  // Modes
  // ****************************************
  typedef enum logic [1:0] {
    MODE_SIMPLE = 2'h0,
    MODE_MAC = 2'h1,
    MODE_TWO = 2'h3,
    MODE_FOUR = 2'h2
  } mode_type;

  typedef enum logic [1:0] {
    WIDTH_9 = 2'h0,
    WIDTH_18 = 2'h1,
    WIDTH_36 = 2'h2
  } width_type;

endpackage

// ===== fabric_model.sv
// Fabric-side model driving the tile's clock gates and clears.
`timescale 1ns/10ps
module fabric_model (
  input wire logic mclk,
  input wire logic [3:0] ena_req,
  input wire logic [3:0] clr_req,
  output logic [3:0] clock_tick,
  output logic [3:0] clock_ena,
  output logic [3:0] async_clear
);
  initial begin
    clock_tick = 4'hf;
    clock_ena = 4'hf;
    async_clear = 4'h0;
  end
  // Controls change just after an edge, as fabric registers would.
  always @(posedge mclk) begin
    clock_tick <= 4'hf;
    clock_ena <= ena_req;
    async_clear <= clr_req;
  end
endmodule

// ===== tb.sv
// Self-checking bench for the multiply tile.
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; $display("unexpected %s exp=%h got=%h", n, e, g); end end
module tb;
  import dsp_tile_pkg::*;
  typedef struct packed {
    logic [8:0] cfg;
    logic [1:0] as;
    logic [71:0] exp;
  } row_type;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [3:0][17:0] a_data = {18'h2, 18'h7, 18'h5, 18'h201};
  logic [3:0][17:0] b_data = {18'h9, 18'h1, 18'h6, 18'h204};
  logic [3:0] tick;
  logic [3:0] ena;
  logic [3:0] clr;
  logic [3:0] ena_req = 4'hf;
  logic [3:0] clr_req = 4'h0;
  logic sign_a = 1'b0;
  logic sign_b = 1'b0;
  logic [17:0] chain_first = '0;
  logic [17:0] chain_second = '0;
  logic [17:0] chain_seen_first;
  logic [17:0] chain_seen_second;
  logic [1:0] add_sub = 2'h3;
  logic [1:0] acc_load = 2'h0;
  logic [OUTW-1:0] result;
  logic [1:0] overflow;
  logic [31:0] d;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  row_type rows [6] = '{'{9'h004, 2'h3, 72'h00000001e000040a04}, '{9'h000, 2'h3, 72'h00000001e000040004},
    '{9'h007, 2'h3, 72'h000000000000040a22}, '{9'h007, 2'h0, 72'h0000000000000409e6},
    '{9'h006, 2'h3, 72'h000000000000040a3b}, '{9'h008, 2'h3, 72'h00000001e0586c0a04}};
  dsp_tile dut (.mclk(mclk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .a_data(a_data), .b_data(b_data),
    .chain_in_first_operand(chain_first), .chain_in_second_operand(chain_second), .clock_tick(tick),
    .clock_ena(ena), .async_clear(clr), .sign_a(sign_a), .sign_b(sign_b), .add_sub(add_sub),
    .acc_load(acc_load), .result(result), .overflow(overflow), .chain_out_first_operand(chain_seen_first),
    .chain_out_second_operand(chain_seen_second));
  fabric_model fab (.mclk(mclk), .ena_req(ena_req), .clr_req(clr_req), .clock_tick(tick),
    .clock_ena(ena), .async_clear(clr));
  initial begin
    forever #5 mclk = ~mclk;
  end
  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      conclude();
    end
  end
  // Both tasks are entered just after a rising edge and return at one.
  task automatic wr(input logic [1:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [31:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    v = reg_rdata;
    @(posedge mclk);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(ADDR_CFG, d);
    `CHK("cfg reset", 32'h0, d)
    rd(ADDR_SEL, d);
    `CHK("sel reset", 32'h0, d)
    wr(ADDR_SEL, 32'h3f);
    rd(ADDR_SEL, d);
    `CHK("sel", 32'h3f, d)
    wr(ADDR_SEL, 32'h0);
    wr(ADDR_CFG, 32'h74);
    rd(ADDR_CFG, d);
    `CHK("cfg", 9'h074, d[8:0])
    wr(ADDR_STAT, 32'h3);
    rd(ADDR_STAT, d);
    `CHK("stat", 32'h0, d)
    rd(2'h3, d);
    `CHK("unmapped", 32'h0, d)
    foreach (rows[i]) begin
      wr(ADDR_CFG, {23'h0, rows[i].cfg});
      add_sub <= rows[i].as;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      `CHK("row result", rows[i].exp, result[71:0])
      @(posedge mclk);
    end
    wr(ADDR_CFG, 32'h4);
    sign_a <= 1'b1;
    a_data[0] <= 18'h3ffff;
    b_data[0] <= 18'h2;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    `CHK("signed", 36'hffffffffe, result[35:0])
    @(posedge mclk);
    sign_a <= 1'b0;
    wr(ADDR_CFG, 32'h44);
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    `CHK("out reg", 36'h00007fffe, result[35:0])
    @(posedge mclk);
    ena_req <= 4'he;
    @(posedge mclk);
    a_data[0] <= 18'h1;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    `CHK("gated", 36'h00007fffe, result[35:0])
    @(posedge mclk);
    clr_req <= 4'h1;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    `CHK("cleared", 36'h0, result[35:0])
    @(posedge mclk);
    clr_req <= 4'h0;
    ena_req <= 4'hf;
    wr(ADDR_CFG, 32'h5);
    a_data[1] <= 18'h1;
    b_data[1] <= 18'h1;
    acc_load <= 2'h1;
    add_sub <= 2'h3;
    @(posedge mclk);
    acc_load <= 2'h0;
    add_sub <= 2'h0;
    @(posedge mclk);
    ce <= 1'b0;
    @(posedge mclk);
    ce <= 1'b1;
    @(negedge mclk);
    `CHK("acc zero", 52'h0, result[51:0])
    `CHK("no flag", 1'b0, overflow[0])
    @(posedge mclk);
    acc_load <= 2'h1;
    add_sub <= 2'h3;
    @(negedge mclk);
    `CHK("underflow", 1'b1, overflow[0])
    @(posedge mclk);
    acc_load <= 2'h0;
    @(negedge mclk);
    `CHK("load flag", 1'b0, overflow[0])
    `CHK("loaded", 52'h1, result[51:0])
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    `CHK("summed", 52'h3, result[51:0])
    @(posedge mclk);
    // Both chains shift a constant word in; parallel operands must be ignored.
    wr(ADDR_CFG, 32'h194);
    chain_first <= 18'h11;
    chain_second <= 18'h22;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    `CHK("chain out first", 18'h11, chain_seen_first)
    `CHK("chain out second", 18'h22, chain_seen_second)
    `CHK("chain product", 36'h000000242, result[35:0])
    @(posedge mclk);
    wr(ADDR_CFG, 32'h188);
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    `CHK("wide ignores chain", 72'h00000000010000c0002, result[71:0])
    @(posedge mclk);
    wr(ADDR_CFG, 32'h4);
    sign_b <= 1'b1;
    b_data[0] <= 18'h3ffff;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    `CHK("signed b", 36'hfffffffff, result[35:0])
    conclude();
  end
endmodule
bind dsp_tile dsp_tile_chk chk (.mclk(mclk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .a_data(a_data), .b_data(b_data), .sign_a(sign_a), .sign_b(sign_b), .add_sub(add_sub),
  .result(result), .overflow(overflow));
